// [decoder_regs.svh]
// width and bit position constants for the instruction field decoder
// assumes a single clock domain and a synchronous active-high reset
// ****************************************************************
// ****************************************************************
`ifndef DECODER_REGS_SVH
`define DECODER_REGS_SVH
`define INSTR_W          16
`define FILE_ADDR_W      8
`define PERIPH_ADDR_W    5
`define LIT8_W           8
`define LIT13_W          13
`define TBL_PTR_W        16
`define TBL_LAT_W        16
`define INT_DIS_BIT      4
`define QPHASE_W         2
`define QPHASE_LAST      2'h3
`define DEST_BIT         8
`define TBL_T_BIT        9
`define TBL_I_BIT        8
`define BIT_SEL_LSB      8
`define BIT_SEL_W        3
`define PERIPH_LSB       8
`define NOP_WORD         16'h0000
`endif

// [decoder_pkg.sv]
// types shared by the decoder files
// assumes decoder_regs.svh for widths
`include "decoder_regs.svh"
package decoder_pkg;
  typedef enum logic [2:0] {
    CLASS_BYTE, CLASS_BIT, CLASS_MOVE, CLASS_TABLE, CLASS_LITERAL,
    CLASS_CONTROL, CLASS_RESERVED
  } op_class_t;
  typedef enum logic [1:0] {Q_DECODE, Q_READ, Q_PROCESS, Q_WRITE} qphase_t;
endpackage

// [fields_if.sv]
// field bundle between decode and field extraction
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "decoder_regs.svh"
interface fields_if;
  logic [`INSTR_W-1:0] word;
  logic [`FILE_ADDR_W-1:0] file_addr;
  logic [`PERIPH_ADDR_W-1:0] periph_addr;
  logic [`BIT_SEL_W-1:0] bit_sel;
  logic [`LIT13_W-1:0] literal;
  logic [7:0] bit_mask;
  modport src (output word, input file_addr, periph_addr, bit_sel, literal,
               bit_mask);
  modport ext (input word, output file_addr, periph_addr, bit_sel, literal,
               bit_mask);
endinterface
`default_nettype wire

// [field_extract.sv]
// pure field slicing of one instruction word
// assumes word is already registered by the caller
`timescale 1ns/1ps
`default_nettype none
`include "decoder_regs.svh"
module field_extract (
  fields_if.ext f
);
  assign f.file_addr   = f.word[`FILE_ADDR_W-1:0];
  assign f.periph_addr = f.word[`PERIPH_LSB +: `PERIPH_ADDR_W];
  assign f.bit_sel     = f.word[`BIT_SEL_LSB +: `BIT_SEL_W];
  assign f.literal     = f.word[`LIT13_W-1:0];
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_mask
      assign f.bit_mask[gi] = (f.bit_sel == `BIT_SEL_W'(gi));
    end
  endgenerate
endmodule
`default_nettype wire

// [instruction_field_decoder.sv]
// instruction word decoder with quarter-phase sequencer
// assumes program memory presents instr_i before each decode phase
`timescale 1ns/1ps
`default_nettype none
`include "decoder_regs.svh"
module instruction_field_decoder (
  // clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      reset_i,
  // program memory side
  input  wire logic [`INSTR_W-1:0]       instr_i,
  output logic                           fetch_o,
  // execution feedback
  input  wire logic                      cond_true_i,
  input  wire logic                      pc_changed_i,
  // phase
  output logic [`QPHASE_W-1:0]           qphase_o,
  output logic                           cycle_start_o,
  // decoded fields
  output logic [2:0]                     op_class_o,
  output logic [`FILE_ADDR_W-1:0]        file_addr_o,
  output logic [`PERIPH_ADDR_W-1:0]      periph_addr_o,
  output logic [`BIT_SEL_W-1:0]          bit_sel_o,
  output logic [7:0]                     bit_mask_o,
  output logic [`LIT8_W-1:0]             literal8_o,
  output logic [`LIT13_W-1:0]            literal13_o,
  output logic                           lit13_valid_o,
  // destination, table, cycle and interrupt controls
  output logic                           write_working_register_o,
  output logic                           write_file_o,
  output logic                           table_high_byte_o,
  output logic                           table_pointer_inc_o,
  output logic                           two_cycle_o,
  output logic                           nop_cycle_o,
  output logic                           reserved_o,
  output logic [`INT_DIS_BIT:0]          int_disable_pos_o
);
  // ****************************************************************
  // quarter phase counter
  // ****************************************************************
  logic [`QPHASE_W-1:0] q_q;
  wire                  q_last = (q_q == `QPHASE_LAST);
  always_ff @(posedge clk_i) begin
    if (reset_i) q_q <= '0;
    else q_q <= q_q + 2'h1;
  end
  assign qphase_o      = q_q;
  assign cycle_start_o = (q_q == 2'h0);
  assign fetch_o       = q_last;

  // ****************************************************************
  // instruction register and second-cycle nop
  // ****************************************************************
  logic [`INSTR_W-1:0] ir_q;
  logic                nop_q;
  wire                 hi4_a = (ir_q[15:12] == 4'hA);
  wire                 is_tbl_xfer = hi4_a & ir_q[11];
  wire                 extra_cycle = ~nop_q &
                       (is_tbl_xfer | cond_true_i | pc_changed_i);
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ir_q  <= `NOP_WORD;
      nop_q <= 1'b0;
    end else if (q_last) begin
      ir_q  <= extra_cycle ? `NOP_WORD : instr_i;
      nop_q <= extra_cycle;
    end
  end

  fields_if fb ();
  assign fb.word = ir_q;
  field_extract u_fields (.f(fb));

  // ****************************************************************
  // class decode
  // ****************************************************************
  logic [2:0] cls;
  wire        is_byte   = (ir_q[15:14] == 2'h0);
  wire        is_move   = (ir_q[15:14] == 2'h1);
  wire        is_bit    = (ir_q[15:13] == 3'h4);
  wire        is_table  = hi4_a;
  wire        is_lit    = (ir_q[15:12] == 4'hB);
  wire        is_ctrl   = (ir_q[15:13] == 3'h6) | (ir_q[15:13] == 3'h7);
  wire        is_s_form = is_byte & (ir_q[13:10] == 4'hA | ir_q[13:10] == 4'hB);
  wire        is_nop    = (ir_q[15:8] == 8'h00);
  // 0x00 high byte with nonzero low byte is an unused encoding
  wire        is_rsvd   = (is_nop & (ir_q[7:0] != 8'h00)) |
                          (ir_q[15:12] == 4'h9);
  always_comb begin
    cls = decoder_pkg::CLASS_RESERVED;
    if (is_rsvd) cls = decoder_pkg::CLASS_RESERVED;
    else if (is_byte) cls = decoder_pkg::CLASS_BYTE;
    else if (is_move) cls = decoder_pkg::CLASS_MOVE;
    else if (is_bit) cls = decoder_pkg::CLASS_BIT;
    else if (is_table) cls = decoder_pkg::CLASS_TABLE;
    else if (is_lit) cls = decoder_pkg::CLASS_LITERAL;
    else if (is_ctrl) cls = decoder_pkg::CLASS_CONTROL;
  end

  // ****************************************************************
  // destination selects
  // ****************************************************************
  wire dbit = ir_q[`DEST_BIT];
  // s form: 0 both, 1 file only; d form: 0 working, 1 file
  wire wr_w = ~is_rsvd & ~is_nop & is_byte &
              (is_s_form ? ~dbit : ~dbit);
  wire wr_f = ~is_rsvd & ~is_nop & is_byte & (is_s_form | dbit);

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      op_class_o               <= decoder_pkg::CLASS_BYTE;
      file_addr_o              <= '0;
      periph_addr_o            <= '0;
      bit_sel_o                <= '0;
      bit_mask_o               <= '0;
      literal8_o               <= '0;
      literal13_o              <= '0;
      lit13_valid_o            <= 1'b0;
      write_working_register_o <= 1'b0;
      write_file_o             <= 1'b0;
      table_high_byte_o        <= 1'b0;
      table_pointer_inc_o      <= 1'b0;
      two_cycle_o              <= 1'b0;
      nop_cycle_o              <= 1'b0;
      reserved_o               <= 1'b0;
    end else begin
      op_class_o               <= cls;
      file_addr_o              <= fb.file_addr;
      periph_addr_o            <= fb.periph_addr;
      bit_sel_o                <= fb.bit_sel;
      // reserved words touch no bit, so the mask stays clear
      bit_mask_o               <= (is_bit & ~is_rsvd) ? fb.bit_mask
                                                      : 8'h00;
      literal8_o               <= fb.literal[`LIT8_W-1:0];
      literal13_o              <= fb.literal;
      lit13_valid_o            <= (ir_q[15:13] == 3'h7);
      write_working_register_o <= wr_w & ~nop_q;
      write_file_o             <= wr_f & ~nop_q;
      table_high_byte_o        <= is_table & ir_q[`TBL_T_BIT];
      // x bit of latch-only forms ignored
      table_pointer_inc_o      <= is_tbl_xfer & ir_q[`TBL_I_BIT];
      two_cycle_o              <= extra_cycle;
      nop_cycle_o              <= nop_q | is_rsvd;
      reserved_o               <= is_rsvd;
    end
  end
  // one-hot pointer to global interrupt disable position
  assign int_disable_pos_o = {1'b1, {`INT_DIS_BIT{1'b0}}};
endmodule
`default_nettype wire

// [decode_monitor.sv]
// port checker for the instruction field decoder
// assumes one clock and the synchronous reset
`timescale 1ns/1ps
`default_nettype none
module decode_monitor (
  // watched ports
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        fetch_o,
  input wire logic        cond_true_i,
  input wire logic        pc_changed_i,
  input wire logic [1:0]  qphase_o,
  input wire logic [2:0]  op_class_o,
  input wire logic [7:0]  file_addr_o,
  input wire logic [4:0]  periph_addr_o,
  input wire logic [2:0]  bit_sel_o,
  input wire logic [7:0]  bit_mask_o,
  input wire logic [12:0] literal13_o,
  input wire logic        write_file_o,
  input wire logic        nop_cycle_o,
  input wire logic        reserved_o,
  input wire logic        cycle_start_o,
  input wire logic [7:0]  literal8_o,
  input wire logic [4:0]  int_disable_pos_o
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_rest; (qphase_o != 2'h0) [*3]; endsequence
  sequence s_back; qphase_o == 2'h0; endsequence
  a_fetch_phase: assert property (fetch_o == (qphase_o == 2'h3))
    else $error("fetch outside last phase");
  a_phase_step: assert property (1'b1 |=> qphase_o == $past(qphase_o) + 2'h1)
    else $error("phase out of order");
  a_four_periods: assert property ($fell(qphase_o == 2'h0) |-> s_rest ##1 s_back)
    else $error("cycle not four periods");
  a_fields_stand: assert property (qphase_o != 2'h1 |->
    $stable({file_addr_o, literal13_o, op_class_o, bit_mask_o}))
    else $error("fields moved mid cycle");
  a_mask_bit: assert property (bit_mask_o ==
    ((op_class_o == 3'h1) ? 8'h01 << bit_sel_o : 8'h00))
    else $error("bit mask wrong");
  a_skip_nop: assert property (fetch_o && (cond_true_i || pc_changed_i)
    |-> ##2 nop_cycle_o && !write_file_o && file_addr_o == 8'h00)
    else $error("skip did not force nop");
  a_periph_field: assert property (periph_addr_o == literal13_o[12:8])
    else $error("peripheral field wrong");
  a_int_disable_pos: assert property (int_disable_pos_o == 5'h10)
    else $error("interrupt disable position wrong");
  a_cycle_start: assert property (cycle_start_o == (qphase_o == 2'h0))
    else $error("cycle start outside decode phase");
  a_short_literal: assert property (literal8_o == literal13_o[7:0])
    else $error("short literal field wrong");
  a_reserved_nop: assert property (reserved_o |-> nop_cycle_o && !write_file_o)
    else $error("reserved word not nop");
endmodule
bind instruction_field_decoder decode_monitor mon (.clk_i(clk_i),
  .reset_i(reset_i), .fetch_o(fetch_o), .cond_true_i(cond_true_i),
  .pc_changed_i(pc_changed_i), .qphase_o(qphase_o), .op_class_o(op_class_o),
  .file_addr_o(file_addr_o), .periph_addr_o(periph_addr_o),
  .bit_sel_o(bit_sel_o), .bit_mask_o(bit_mask_o), .literal13_o(literal13_o),
  .write_file_o(write_file_o), .nop_cycle_o(nop_cycle_o),
  .reserved_o(reserved_o), .cycle_start_o(cycle_start_o),
  .literal8_o(literal8_o), .int_disable_pos_o(int_disable_pos_o));
`default_nettype wire

// [prog_mem_model.sv]
// program memory model feeding instruction words
// assumes the bench picks each word
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
  input  wire logic        fetch_i,
  input  wire logic [15:0] word_i,
  output logic      [15:0] instr_o
);
  // released bus shows the inverse so a stale word never passes
  assign instr_o = fetch_i ? word_i : ~word_i;
endmodule
`default_nettype wire

// [instruction_field_decoder_tb.sv]
// self-checking bench for the instruction field decoder
// assumes the memory model and the bound port checker
`timescale 1ns/1ps
`default_nettype none
module instruction_field_decoder_tb;
  logic        clk_i, reset_i, cond_true_i, pc_changed_i, disc, fetch_o;
  logic        wwr, wf, th, ti, nopc, rsv;
  logic [1:0]  qphase_o;
  logic [7:0]  file_addr_o, bit_mask_o;
  logic [12:0] literal13_o;
  logic [15:0] word, instr_i;
  logic [16:0] seed;
  logic [34:0] e;
  logic [34:0] expq[$];
  logic [7:0]  hi[4] = '{8'h0E, 8'h0F, 8'h28, 8'h29};
  int          n_fail, compares;
  instruction_field_decoder dut (.clk_i(clk_i), .reset_i(reset_i),
    .instr_i(instr_i), .fetch_o(fetch_o), .cond_true_i(cond_true_i),
    .pc_changed_i(pc_changed_i), .qphase_o(qphase_o), .cycle_start_o(),
    .op_class_o(), .file_addr_o(file_addr_o), .periph_addr_o(),
    .bit_sel_o(), .bit_mask_o(bit_mask_o), .literal8_o(),
    .literal13_o(literal13_o), .lit13_valid_o(),
    .write_working_register_o(wwr), .write_file_o(wf),
    .table_high_byte_o(th), .table_pointer_inc_o(ti), .two_cycle_o(),
    .nop_cycle_o(nopc), .reserved_o(rsv), .int_disable_pos_o());
  prog_mem_model mem (.fetch_i(fetch_o), .word_i(word), .instr_o(instr_i));
  function automatic logic [16:0] nxt(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  function automatic logic [34:0] expect_of(input logic [15:0] w,
                                            input logic nop);
    logic byt, tbl, rs;
    byt = (w[15:14] == 2'h0) && (w[15:8] != 8'h00);
    tbl = (w[15:12] == 4'hA);
    rs = ((w[15:8] == 8'h00) && (w[7:0] != 8'h00)) || (w[15:12] == 4'h9);
    return {w[7:0], w[12:0],
      (w[15:13] == 3'h4 && !rs) ? 8'h01 << w[10:8] : 8'h00,
      byt & ~w[8], byt & (w[8] | (w[13:11] == 3'h5)), tbl & w[9],
      tbl & w[11] & w[8], rs, nop | rs};
  endfunction
  task automatic check(input string what, input logic [12:0] seen,
                       input logic [12:0] want);
    compares++;
    if (seen !== want) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask
  // a word fetched under a true test or after a table transfer is dropped
  task automatic issue(input logic [15:0] w, input logic c, input logic p);
    for (int i = 0; i < 8 && fetch_o !== 1'b1; i++) @(negedge clk_i);
    word = w;
    cond_true_i = c;
    pc_changed_i = p;
    expq.push_back((disc | c | p) ? expect_of(16'h0000, 1'b1) : expect_of(w, 1'b0));
    disc = !(disc | c | p) && (w[15:11] == 5'h15);
    @(negedge clk_i);
    cond_true_i = 1'b0;
    pc_changed_i = 1'b0;
  endtask
  task automatic results();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(negedge clk_i) begin
    if (qphase_o === 2'h2 && expq.size() > 0) begin
      e = expq.pop_front();
      check("file_addr", 13'(file_addr_o), 13'(e[34:27]));
      check("literal13", literal13_o, e[26:14]);
      check("bit_mask", 13'(bit_mask_o), 13'(e[13:6]));
      check("dest", 13'({wwr, wf}), 13'(e[5:4]));
      check("table", 13'({th, ti}), 13'(e[3:2]));
      check("nop", 13'({rsv, nopc}), 13'(e[1:0]));
    end
  end
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    n_fail++;
    results();
  end
  initial begin
    {reset_i, cond_true_i, pc_changed_i, disc, word} = {4'h8, 16'h0000};
    seed = 17'h1169C;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    for (int i = 0; i < 16; i++) begin
      seed = nxt(seed);
      issue((i < 8) ? {hi[i % 4], seed[7:0]} : {5'h11, 3'(i), seed[7:0]},
            1'b0, 1'b0);
    end
    $display("test fields done");
    issue(16'h0005, 1'b0, 1'b0);
    issue(16'h9A5C, 1'b0, 1'b0);
    issue(16'hA933, 1'b0, 1'b0);
    issue(16'h0E44, 1'b0, 1'b0);
    issue(16'hAE55, 1'b0, 1'b0);
    issue(16'h2966, 1'b0, 1'b0);
    issue(16'hA211, 1'b0, 1'b0);
    issue(16'h0F77, 1'b1, 1'b0);
    issue(16'h0E12, 1'b0, 1'b0);
    issue(16'h2A88, 1'b0, 1'b1);
    issue(16'hFFFF, 1'b0, 1'b0);
    issue(16'h0E00, 1'b0, 1'b0);
    repeat (8) @(negedge clk_i);
    check("queue", 13'(expq.size()), 13'h0000);
    $display("test control done");
    results();
  end
endmodule
`default_nettype wire
